// ==== hdl/ahbm_driver.sv ====
/*
 * Bus master signal driver: turns caller burst commands and a write data
 * stream into the address, control and write data signals of the bus, and
 * returns read data and the response of each beat.
 * Assumes bus ready, response and read data come from logic on mclk_i.
 */
`timescale 1ns/1ps
`default_nettype none

`include "ahbm_params.svh"

module ahbm_driver
    import ahbm_pkg::*;
#(
    parameter int DATA_W   = 32, // Write and read data width.
    parameter bit EXT_MEM  = 1'b0, // Extended memory types present.
    parameter bit SECURE   = 1'b0, // Secure transfers present.
    parameter bit EXCL     = 1'b0  // Exclusive transfers present.
) (
    input  wire logic              mclk_i,        // Bus clock.
    input  wire logic              reset_n_i,     // Asynchronous reset, low.
    input  wire logic              cmd_valid_i,   // Burst command offered.
    input  wire ahbm_cmd_t         cmd_i,         // Burst command.
    output logic                   cmd_ready_o,   // Command taken this cycle.
    input  wire logic              wdata_valid_i, // Write beat offered.
    input  wire logic [DATA_W-1:0] wdata_i,       // Write beat data.
    output logic                   wdata_ready_o, // Write beat taken.
    input  wire logic              hready_i,      // Bus ready.
    input  wire logic              hresp_i,       // Bus response, high on error.
    input  wire logic [DATA_W-1:0] hrdata_i,      // Bus read data.
    output ahbm_bus_t              bus_o,         // Address-phase signals.
    output logic [DATA_W-1:0]      hwdata_o,      // Write data bus.
    output logic                   rsp_valid_o,   // Beat finished.
    output logic                   rsp_err_o,     // Finished beat had an error.
    output logic [DATA_W-1:0]      rsp_rdata_o    // Read data of finished beat.
);

    // Widths the logic cannot serve are refused at elaboration.
    if (DATA_W < 8 || DATA_W > 1024 || (DATA_W & (DATA_W - 1)) != 0) begin : g_chk
        $error("DATA_W must be a power of two from 8 to 1024");
    end

    logic [1:0]              rst_sync_q;  // Reset release synchroniser.
    logic                    rst_n;       // Synchronised reset.
    ahbm_bus_t               a_q;         // Address phase in flight.
    ahbm_bus_t               a_d;         // Next address phase.
    logic [DATA_W-1:0]       aw_q;        // Write data of the address beat.
    logic [DATA_W-1:0]       hwdata_q;    // Write data of the data phase.
    logic [`AHBM_LEN_W-1:0]  left_q;      // Beats still to issue.
    logic [`AHBM_LEN_W-1:0]  left_d;      // Next beats count.
    logic                    dp_q;        // A data phase is active.
    logic                    rv_q;        // Response valid register.
    logic                    re_q;        // Response error register.
    logic [DATA_W-1:0]       rd_q;        // Response data register.

    // Release the reset through two flip-flops.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Address phase advances only on a ready cycle; otherwise all holds.
    wire adv       = hready_i;
    wire a_active  = a_q.htrans[1];
    wire in_burst  = (left_q != '0);
    wire beat_data = a_q.hwrite ? wdata_valid_i : 1'b1;
    wire go_seq    = adv && in_burst && beat_data;
    wire go_busy   = adv && in_burst && !beat_data;
    wire go_new    = adv && !in_burst && cmd_valid_i && (!cmd_i.write || wdata_valid_i);

    // Beats of the incoming command, the one issued now included.
    wire [`AHBM_LEN_W-1:0] cmd_len = (cmd_i.len == '0) ? `AHBM_LEN_W'h1 : cmd_i.len;
    wire [`AHBM_LEN_W-1:0] cmd_beats =
        (cmd_i.burst == `AHBM_BURST_SINGLE) ? `AHBM_LEN_W'h1  :
        (cmd_i.burst == `AHBM_BURST_INCR)   ? cmd_len         :
        (cmd_i.burst[2:1] == 2'h1)          ? `AHBM_LEN_W'h4  :
        (cmd_i.burst[2:1] == 2'h2)          ? `AHBM_LEN_W'h8  : `AHBM_LEN_W'h10;

    // Next beat address, wrapped at the burst boundary for wrapping bursts.
    wire [`AHBM_ADDR_W-1:0] step     = `AHBM_ADDR_W'h1 << a_q.hsize;
    wire [`AHBM_ADDR_W-1:0] inc_addr = a_q.haddr + step;
    // Wrap span is beats times step: a shift of 2, 3 or 4 for 4, 8 or 16 beats.
    wire [2:0]              wsh      = {1'b0, a_q.hburst[2:1]} + 3'h1;
    wire                    is_wrap  = !a_q.hburst[0] && (a_q.hburst != `AHBM_BURST_SINGLE);
    wire [`AHBM_ADDR_W-1:0] wmask    = (step << wsh) - `AHBM_ADDR_W'h1;
    wire [`AHBM_ADDR_W-1:0] nxt_addr = is_wrap ?
                                       ((a_q.haddr & ~wmask) | (inc_addr & wmask)) : inc_addr;
    // A busy beat already shows the next address, so it is not advanced again.
    wire [`AHBM_ADDR_W-1:0] seq_addr = a_active ? nxt_addr : a_q.haddr;

    // Optional signals are forced low when their capability is absent.
    wire [`AHBM_PROT_W-1:0] prot_v = EXT_MEM ? cmd_i.prot :
                                     {3'h0, cmd_i.prot[`AHBM_PROT_BASE_W-1:0]};

    // Select the next address-phase group.
    always_comb begin
        a_d    = a_q;
        left_d = left_q;
        if (go_new) begin
            a_d.haddr     = cmd_i.addr;
            a_d.hburst    = cmd_i.burst;
            a_d.hsize     = cmd_i.size;
            a_d.htrans    = `AHBM_TRANS_NONSEQ;
            a_d.hwrite    = cmd_i.write;
            a_d.hprot     = prot_v;
            a_d.hmastlock = cmd_i.lock;
            a_d.hnonsec   = SECURE ? cmd_i.nonsec : 1'b0;
            a_d.hexcl     = EXCL ? cmd_i.excl : 1'b0;
            a_d.hmaster   = EXCL ? cmd_i.mid : `AHBM_RST_MID;
            left_d        = cmd_beats - `AHBM_LEN_W'h1;
        end else if (go_seq) begin
            // Direction and control are not reloaded inside a burst.
            a_d.haddr  = seq_addr;
            a_d.htrans = `AHBM_TRANS_SEQ;
            left_d     = left_q - `AHBM_LEN_W'h1;
        end else if (go_busy) begin
            // Write data is late: a busy beat shows the next address.
            a_d.haddr  = seq_addr;
            a_d.htrans = `AHBM_TRANS_BUSY;
        end else if (adv) begin
            // No work: idle, lock released.
            a_d.htrans    = `AHBM_TRANS_IDLE;
            a_d.hmastlock = 1'b0;
            a_d.hexcl     = 1'b0;
        end
    end

    assign cmd_ready_o   = go_new;
    assign wdata_ready_o = (go_new && cmd_i.write) || (go_seq && a_q.hwrite);

    // Address-phase and burst registers; launched on the rising clock edge.
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            a_q <= '{haddr: `AHBM_RST_ADDR, hburst: `AHBM_BURST_SINGLE, hsize: 3'h0,
                     htrans: `AHBM_TRANS_IDLE, hwrite: 1'b0, hprot: `AHBM_RST_PROT,
                     hmastlock: 1'b0, hnonsec: 1'b0, hexcl: 1'b0, hmaster: `AHBM_RST_MID};
            left_q <= '0;
        end else begin
            a_q    <= a_d;
            left_q <= left_d;
        end
    end

    // Write data rides with its address beat, then moves to the data phase.
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            aw_q     <= '0;
            hwdata_q <= '0;
        end else begin
            if (wdata_ready_o) begin
                aw_q <= wdata_i;
            end
            if (adv && a_active && a_q.hwrite) begin
                hwdata_q <= aw_q;
            end
        end
    end

    // Data phase tracking and per-beat response capture.
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            dp_q <= 1'b0;
            rv_q <= 1'b0;
            re_q <= 1'b0;
            rd_q <= '0;
        end else begin
            rv_q <= dp_q && hready_i;
            if (hready_i) begin
                dp_q <= a_active;
            end
            if (dp_q && hready_i) begin
                re_q <= hresp_i;
                rd_q <= hrdata_i;
            end
        end
    end

    assign bus_o       = a_q;
    assign hwdata_o    = hwdata_q;
    assign rsp_valid_o = rv_q;
    assign rsp_err_o   = re_q;
    assign rsp_rdata_o = rd_q;

    // Checks on the driven bus signals.
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n);

    stall_hold_a: assert property ($past(!hready_i) |-> $stable(bus_o))
        else $error("address phase changed during a stall");
    wdata_hold_a: assert property (!hready_i |=> $stable(hwdata_o))
        else $error("write data changed during a stall");
    dir_const_a: assert property (bus_o.htrans inside {`AHBM_TRANS_SEQ, `AHBM_TRANS_BUSY}
                                  |-> $stable(bus_o.hwrite))
        else $error("direction changed inside a burst");
    seq_order_a: assert property (bus_o.htrans == `AHBM_TRANS_SEQ |-> $past(bus_o.htrans) != 2'h0)
        else $error("sequential beat after idle");
    incr_step_a: assert property ($past(hready_i) && $past(bus_o.htrans[1]) &&
                                  bus_o.htrans[0] && bus_o.hburst[0]
                                  |-> bus_o.haddr == $past(bus_o.haddr) + ($past(step)))
        else $error("incrementing burst address step wrong");
    wrap_bound_a: assert property (bus_o.htrans[0] && is_wrap
                                   |-> (bus_o.haddr & ~wmask) == ($past(bus_o.haddr) & ~wmask))
        else $error("wrapping burst left its boundary");
    opt_off_a: assert property ((!EXT_MEM |-> bus_o.hprot[6:4] == 3'h0) and
                                (!SECURE |-> !bus_o.hnonsec))
        else $error("absent protection or secure signal driven");
    excl_off_a: assert property (!EXCL |-> !bus_o.hexcl && bus_o.hmaster == `AHBM_RST_MID)
        else $error("exclusive signals driven without support");
    resp_time_a: assert property (dp_q && hready_i |=> rsp_valid_o && rsp_err_o == $past(hresp_i))
        else $error("finished beat not reported");

    cover_burst_c: cover property (bus_o.htrans == `AHBM_TRANS_NONSEQ ##1
                                   bus_o.htrans == `AHBM_TRANS_SEQ [*3]);
    cover_busy_c:  cover property (bus_o.htrans == `AHBM_TRANS_BUSY);
    cover_stall_c: cover property (bus_o.htrans[1] && !hready_i ##1 hready_i);
    cover_wrap_c:  cover property (is_wrap && bus_o.htrans == `AHBM_TRANS_SEQ &&
                                   bus_o.haddr < $past(bus_o.haddr));

endmodule

`default_nettype wire

// ==== hdl/ahbm_params.svh ====
/*
 * Constants of the bus master signal driver: field widths, transfer-type and
 * burst-type codes, and reset values of the address-phase signals.
 * Assumes it is included by bare name from the package and the driver.
 */
`ifndef AHBM_PARAMS_SVH
`define AHBM_PARAMS_SVH

`define AHBM_ADDR_W      32
`define AHBM_PROT_W      7
`define AHBM_PROT_BASE_W 4
`define AHBM_MID_W       4
`define AHBM_LEN_W       8

`define AHBM_TRANS_IDLE   2'h0
`define AHBM_TRANS_BUSY   2'h1
`define AHBM_TRANS_NONSEQ 2'h2
`define AHBM_TRANS_SEQ    2'h3

`define AHBM_BURST_SINGLE 3'h0
`define AHBM_BURST_INCR   3'h1
`define AHBM_BURST_WRAP4  3'h2
`define AHBM_BURST_INCR4  3'h3
`define AHBM_BURST_WRAP8  3'h4
`define AHBM_BURST_INCR8  3'h5
`define AHBM_BURST_WRAP16 3'h6
`define AHBM_BURST_INCR16 3'h7

`define AHBM_RST_ADDR  32'h0000_0000
`define AHBM_RST_PROT  7'h03
`define AHBM_RST_MID   4'h0

`endif

// ==== hdl/ahbm_pkg.sv ====
/*
 * Types of the bus master signal driver: the address-phase signal group and
 * the caller's burst command.
 * Assumes ahbm_params.svh sits beside it on the include path.
 */
`include "ahbm_params.svh"

package ahbm_pkg;

    // Address and control signals launched together toward slaves and decoder.
    typedef struct packed {
        logic [`AHBM_ADDR_W-1:0] haddr;     // System address.
        logic [2:0]              hburst;    // Burst type.
        logic [2:0]              hsize;     // Transfer size, log2 of bytes.
        logic [1:0]              htrans;    // Transfer type.
        logic                    hwrite;    // High for write.
        logic [`AHBM_PROT_W-1:0] hprot;     // Protection and memory type.
        logic                    hmastlock; // Locked sequence member.
        logic                    hnonsec;   // Non-secure when high.
        logic                    hexcl;     // Exclusive sequence member.
        logic [`AHBM_MID_W-1:0]  hmaster;   // Master identifier.
    } ahbm_bus_t;

    // One burst request from the caller.
    typedef struct packed {
        logic [`AHBM_ADDR_W-1:0] addr;      // First beat address.
        logic [2:0]              burst;     // Burst type code.
        logic [2:0]              size;      // Size code.
        logic                    write;     // Direction of the whole burst.
        logic [`AHBM_PROT_W-1:0] prot;      // Protection bits.
        logic                    lock;      // Locked transfer.
        logic                    nonsec;    // Non-secure transfer.
        logic                    excl;      // Exclusive transfer.
        logic [`AHBM_MID_W-1:0]  mid;       // Thread identifier.
        logic [`AHBM_LEN_W-1:0]  len;       // Beats of an open incrementing burst.
    } ahbm_cmd_t;

endpackage

// ==== testbench/ahbm_slave_model.sv ====
/*
 * Behavioural bus slave standing behind the master driver: a small word
 * memory that inserts a chosen number of wait states per data phase and
 * answers with an error for any address that has bit 12 set.
 * Assumes one bus clock and the active-low reset of the bench.
 */
`timescale 1ns/1ps
`default_nettype none

module ahbm_slave_model
    import ahbm_pkg::*;
(
    input  wire logic        mclk_i,    // Bus clock.
    input  wire logic        reset_n_i, // Reset, active low.
    input  wire ahbm_bus_t   bus_i,     // Address-phase signals.
    input  wire logic [31:0] hwdata_i,  // Write data bus.
    input  wire logic [1:0]  waits_i,   // Wait states per data phase.
    output logic             hready_o,  // Transfer complete.
    output logic             hresp_o,   // High on error.
    output logic [31:0]      hrdata_o   // Read data bus.
);
    logic [31:0] mem_q [0:63]; // Word store.
    logic        act_q;        // A data phase is in progress.
    logic        wr_q;         // That data phase writes.
    logic        err_q;        // That data phase fails.
    logic [5:0]  idx_q;        // Word index of that data phase.
    logic [1:0]  cnt_q;        // Wait states inserted so far.
    logic [31:0] last_q;       // Last read bus value, inverted when idle.

    // This model stands for a single-master interconnect, so the master identifier
    // arrives unmodified and is already unique in the system.
    // Wait states stretch only the data phase.
    assign hready_o = !act_q || (cnt_q == waits_i);
    assign hresp_o  = act_q && err_q && hready_o;
    // Outside a read data phase the bus toggles so stale data never matches.
    assign hrdata_o = (act_q && !wr_q) ? mem_q[idx_q] : ~last_q;

    // Address is sampled on the rising edge when ready is high.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            act_q  <= 1'b0;
            cnt_q  <= 2'h0;
            last_q <= 32'h0000_0000;
        end else begin
            last_q <= hrdata_o;
            if (hready_o) begin
                // Write data is taken at the end of the data phase.
                if (act_q && wr_q && !err_q) begin
                    mem_q[idx_q] <= hwdata_i;
                end
                act_q <= bus_i.htrans[1];
                wr_q  <= bus_i.hwrite;
                idx_q <= bus_i.haddr[7:2];
                err_q <= bus_i.haddr[12];
                cnt_q <= 2'h0;
            end else begin
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/tb_bus_master_signal_driver.sv ====
/*
 * Self-checking bench of the master driver: bursts of every type written
 * and read back through the slave model with wait states, attribute fields,
 * wrapping, an error reply and reset values.
 * Assumes the slave model and the package are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

`include "ahbm_params.svh"

module tb_bus_master_signal_driver;
    import ahbm_pkg::*;
    logic        mclk_i = 1'b0;        // Bus clock, 200 MHz.
    logic        reset_n_i = 1'b0;     // Reset, active low.
    logic        cmd_valid_i = 1'b0;   // Command offered.
    ahbm_cmd_t   cmd_i = '0;           // Command.
    logic        wdata_valid_i = 1'b0; // Write beat offered.
    logic [31:0] wdata_i = '0;         // Write beat.
    logic [1:0]  waits = 2'h0;         // Slave wait states.
    logic        cmd_ready_o, wdata_ready_o, hready_i, hresp_i;
    logic        rsp_valid_o, rsp_err_o, hold_q;
    logic [31:0] hrdata_i, hwdata_o, rsp_rdata_o;
    ahbm_bus_t   bus_o, bus_prev, seen;
    logic        dir_q;                // Direction of the running burst.
    logic [31:0] wbuf [0:16];          // Beats to write.
    logic [31:0] rbuf [0:15];          // Beats returned.
    logic        ebuf [0:15];          // Error flags returned.
    int          n_errors = 0, comparisons = 0, cycles = 0;
    int          n_busy = 0;           // Busy cycles seen on the bus.

    always #2.5 mclk_i = ~mclk_i;

    ahbm_driver #(.DATA_W(32), .EXT_MEM(1'b1), .SECURE(1'b1), .EXCL(1'b1)) dut (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i),
        .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .wdata_valid_i(wdata_valid_i),
        .wdata_i(wdata_i), .wdata_ready_o(wdata_ready_o), .hready_i(hready_i),
        .hresp_i(hresp_i), .hrdata_i(hrdata_i), .bus_o(bus_o), .hwdata_o(hwdata_o),
        .rsp_valid_o(rsp_valid_o), .rsp_err_o(rsp_err_o), .rsp_rdata_o(rsp_rdata_o));

    ahbm_slave_model slave (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus_i(bus_o), .hwdata_i(hwdata_o),
        .waits_i(waits), .hready_o(hready_i), .hresp_o(hresp_i), .hrdata_o(hrdata_i));

    // Compares one value and counts the outcome.
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Watches the bus each edge: stall hold, burst direction, busy beats, last accepted NONSEQ address phase.
    always @(posedge mclk_i) begin
        cycles++;
        if (hold_q === 1'b1) check(bus_o, bus_prev);
        if (bus_o.htrans === `AHBM_TRANS_SEQ) check(bus_o.hwrite, dir_q);
        if (bus_o.htrans === `AHBM_TRANS_NONSEQ) dir_q = bus_o.hwrite;
        if (bus_o.htrans === `AHBM_TRANS_BUSY) n_busy++;
        if (hready_i && bus_o.htrans === `AHBM_TRANS_NONSEQ) seen = bus_o;
        hold_q = reset_n_i && !hready_i;
        bus_prev = bus_o;
        // The ceiling comes last so that nothing runs after the closing report.
        if (cycles > 20000) begin
            n_errors++;
            close_out();
        end
    end

    // Number of beats a command asks for.
    function automatic int beats(input ahbm_cmd_t c);
        if (c.burst == `AHBM_BURST_SINGLE) return 1;
        if (c.burst == `AHBM_BURST_INCR) return (c.len == 0) ? 1 : int'(c.len);
        return 4 << ((int'(c.burst) - 2) >> 1);
    endfunction

    // Issues one burst, feeds its write beats and collects every response.
    // With late set, the third write beat is withheld for one cycle.
    // A clock edge passes first, so no strobe is set twice in one time step.
    task automatic xfer(input ahbm_cmd_t c, input bit late = 1'b0);
        int nb, sent, got, k;
        logic took, hole, holed;
        @(posedge mclk_i);
        #1;
        nb = beats(c);
        sent = 0;
        got = 0;
        took = 1'b0;
        holed = 1'b0;
        cmd_i = c;
        cmd_valid_i = 1'b1;
        wdata_valid_i = c.write;
        wdata_i = wbuf[0];
        for (k = 0; k < 300 && got < nb; k++) begin
            @(negedge mclk_i);
            if (cmd_ready_o === 1'b1) took = 1'b1;
            if (wdata_ready_o === 1'b1) sent++;
            if (rsp_valid_o === 1'b1) begin
                rbuf[got] = rsp_rdata_o;
                ebuf[got] = rsp_err_o;
                got++;
            end
            @(posedge mclk_i);
            #1;
            cmd_valid_i = !took;
            // The offer is withdrawn only right after a beat was taken.
            hole = late && (sent == 2) && !holed;
            holed = holed || hole;
            wdata_valid_i = c.write && (sent < nb) && !hole;
            wdata_i = wbuf[sent];
        end
        check(got, nb);
    endtask

    // Every burst code written and read back, waits varying per code.
    task automatic t_codes();
        ahbm_cmd_t c;
        for (int b = 0; b < 8; b++) begin
            c = '{addr: 32'h0000_0040, burst: b[2:0], size: 3'h2, write: 1'b1,
                  prot: 7'h03, len: 8'h05, default: '0};
            for (int i = 0; i < 16; i++) wbuf[i] = 32'hC0DE_0000 + 32'(b * 16 + i);
            waits = 2'(b % 3);
            xfer(c);
            c.write = 1'b0;
            xfer(c);
            check(seen.hburst, b[2:0]);
            for (int i = 0; i < beats(c); i++) check(rbuf[i], wbuf[i]);
        end
        $display("test codes done");
    endtask

    // A wrapping write read back as an incrementing burst from the boundary.
    task automatic t_wrap();
        ahbm_cmd_t c;
        c = '{addr: 32'h0000_0018, burst: `AHBM_BURST_WRAP4, size: 3'h2,
              write: 1'b1, prot: 7'h03, default: '0};
        for (int i = 0; i < 4; i++) wbuf[i] = 32'hA5A5_0000 + 32'(i);
        waits = 2'h1;
        xfer(c);
        c = '{addr: 32'h0000_0010, burst: `AHBM_BURST_INCR4, size: 3'h2,
              prot: 7'h03, default: '0};
        xfer(c);
        for (int i = 0; i < 4; i++) check(rbuf[i], wbuf[(i + 2) % 4]);
        $display("test wrap done");
    endtask

    // An incrementing write whose third beat comes late, then read back.
    task automatic t_busy();
        ahbm_cmd_t c;
        int b0;
        c = '{addr: 32'h0000_00A0, burst: `AHBM_BURST_INCR4, size: 3'h2, write: 1'b1,
              prot: 7'h03, default: '0};
        for (int i = 0; i < 4; i++) wbuf[i] = 32'h5EED_0000 + 32'(i);
        waits = 2'h0;
        b0 = n_busy;
        xfer(c, 1'b1);
        check(n_busy - b0, 1);
        c.write = 1'b0;
        xfer(c);
        for (int i = 0; i < 4; i++) check(rbuf[i], wbuf[i]);
        $display("test busy done");
    endtask

    // Attribute fields of a single write, then a read that draws an error.
    task automatic t_attr();
        ahbm_cmd_t c;
        c = '{addr: 32'h0000_0084, burst: `AHBM_BURST_SINGLE, size: 3'h1, write: 1'b1,
              prot: 7'h5A, lock: 1'b1, nonsec: 1'b1, excl: 1'b1, mid: 4'h9, len: 8'h00};
        waits = 2'h2;
        xfer(c);
        check(seen.haddr, 32'h0000_0084);
        check(seen.hsize, 3'h1);
        check(seen.hprot, 7'h5A);
        check({seen.hmastlock, seen.hwrite}, 2'h3);
        check({seen.hnonsec, seen.hexcl}, 2'h3);
        check(seen.hmaster, 4'h9);
        c = '{addr: 32'h0000_1000, burst: `AHBM_BURST_SINGLE, size: 3'h2,
              prot: 7'h02, default: '0};
        xfer(c);
        check({seen.hwrite, seen.hmastlock, seen.hprot}, 9'h002);
        check(ebuf[0], 1'b1);
        $display("test attributes done");
    endtask

    // Reset, the scenarios, then the verdict.
    initial begin
        repeat (20) @(posedge mclk_i);
        check(bus_o.htrans, `AHBM_TRANS_IDLE);
        check({bus_o.haddr, bus_o.hprot}, {`AHBM_RST_ADDR, `AHBM_RST_PROT});
        #1;
        reset_n_i = 1'b1;
        repeat (3) @(posedge mclk_i);
        #1;
        t_codes();
        t_wrap();
        t_busy();
        t_attr();
        close_out();
    end
endmodule
`default_nettype wire
